// file: verilog/hbdh_defines.vh
// Purpose: Shared constants of the host bus and DMA handshake block.
// Assumes: Included by bare name from every design file of the block.
// Notes:   Definitions only; no logic lives here.
`ifndef HBDH_DEFINES_VH
`define HBDH_DEFINES_VH

// ==========================================================
// Command codes written in the command phase.
`define HBDH_CMD_HOST_CFG_RD 8'h20
`define HBDH_CMD_HOST_CFG_WR 8'ha0
`define HBDH_CMD_PERIPH_CFG_WR 8'hba
`define HBDH_CMD_PERIPH_CFG_RD 8'hbb
`define HBDH_CMD_STATUS_RD 8'h24

// ==========================================================
// Field positions inside both configuration registers; the merge bit is used in the host one only.
`define HBDH_BIT_REQ_POL 0
`define HBDH_BIT_GRANT_POL 1
`define HBDH_BIT_MERGE 2

// ==========================================================
// Reset values: both polarities active low, channels separate.
`define HBDH_HOST_CFG_RST 16'h0000
`define HBDH_PERIPH_CFG_RST 16'h0000
`define HBDH_CMD_RST 8'h00

// ==========================================================
// Widths and timing.
`define HBDH_DATA_W 16
`define HBDH_BUF_W 17
`define HBDH_SYNC_STAGES 2

`endif

// file: verilog/hbdh_buffer.v
// Purpose: Two-entry buffer with valid and ready on both sides.
// Assumes: One clock; synchronous active-low reset.
// Notes:   Full and empty are exact; a push into a full buffer is refused.
`include "hbdh_defines.vh"

module hbdh_buffer #(
  parameter WIDTH = `HBDH_BUF_W
) (
  // Clock and reset.
  input wire clk,
  input wire nrst,
  // Filling side.
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  // Draining side.
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData,
  // State.
  output wire full
);

  reg [WIDTH-1:0] slot_q [0:1];
  reg wrPtr_q;
  reg rdPtr_q;
  reg [1:0] count_q;
  wire doPush;
  wire doPop;

  // ==========================================================
  // Handshakes come straight from the occupancy count.
  assign inReady = (count_q != 2'h2);
  assign outValid = (count_q != 2'h0);
  assign full = (count_q == 2'h2);
  assign outData = slot_q[rdPtr_q];
  assign doPush = inValid & inReady;
  assign doPop = outValid & outReady;

  // Storage and pointers; push and pop may share a cycle.
  always @(posedge clk) begin
    if (!nrst) begin
      wrPtr_q <= 1'b0;
      rdPtr_q <= 1'b0;
      count_q <= 2'h0;
      slot_q[0] <= {WIDTH{1'b0}};
      slot_q[1] <= {WIDTH{1'b0}};
    end else begin
      if (doPush) begin
        slot_q[wrPtr_q] <= inData;
        wrPtr_q <= ~wrPtr_q;
      end
      if (doPop) begin
        rdPtr_q <= ~rdPtr_q;
      end
      if (doPush && !doPop) begin
        count_q <= count_q + 2'h1;
      end else if (doPop && !doPush) begin
        count_q <= count_q - 2'h1;
      end
    end
  end

endmodule

// file: verilog/hbdh_top.v
// Purpose: Processor parallel port and two-channel DMA handshake of a dual-role USB controller.
// Assumes: Strobes, chip select, data and grants arrive asynchronously to clk (10 MHz).
// Notes:   Strobes must stay low at least three clocks; a command phase selects the register.
`include "hbdh_defines.vh"

// Notes on behaviour
// RULE1: Data bus driven only during reads; all sixteen lines released when idle.
// RULE2: Register access needs chip select low; strobes ignored while it is high. Under an active grant, DMA strobes are taken whatever chip select is.
// RULE3: Read strobe low returns the selected register or buffer word.
// RULE4: Write strobe low captures the bus into the selected register or buffer.
// RULE5: Host request pin active when host part needs data, polarity from host config.
// RULE6: Peripheral request pin active on peripheral need, polarity from peripheral config.
// RULE7: Merge bit routes both parts' requests and grants through the first channel.
// RULE8: First grant input interpreted with polarity from the host config register.
// RULE9: Second grant input interpreted with polarity from the peripheral config register.
// RULE10: Each strobe under an active grant moves one word to or from that part; a write while the buffer is full is dropped.
module hbdh_top (
  // Clock and reset.
  input wire clk,
  input wire nrst,
  // Processor strobes and phase select.
  input wire csN,
  input wire rdN,
  input wire wrN,
  input wire cmdPhase,
  // Data bus as three signals.
  input wire [15:0] dataIn,
  output wire [15:0] dataOut,
  output wire dataOe,
  // DMA pins.
  output wire dmaRequestHost,
  output wire dmaRequestPeriph,
  input wire dmaGrantHost,
  input wire dmaGrantPeriph,
  // Host part user side.
  input wire hostPartNeed,
  input wire [15:0] hostPartRdData,
  output wire hostPartRdPop,
  // Peripheral part user side.
  input wire periphPartNeed,
  input wire [15:0] periphPartRdData,
  output wire periphPartRdPop,
  // Written DMA words toward the parts; bit 16 set means peripheral part.
  output wire dmaWrValid,
  input wire dmaWrReady,
  output wire [16:0] dmaWrData
);

  // ==========================================================
  // Pin synchronisers.
  reg [1:0] csSync_q;
  reg [1:0] rdSync_q;
  reg [1:0] wrSync_q;
  reg [1:0] cmdSync_q;
  reg [1:0] grantHostSync_q;
  reg [1:0] grantPeriphSync_q;
  reg [15:0] dataSyncA_q;
  reg [15:0] dataSyncB_q;
  // Edge history of synchronised signals.
  reg rdPrev_q;
  reg wrPrev_q;
  reg csPrev_q;
  reg cmdPrev_q;
  reg [15:0] dataPrev_q;
  // Registers and state.
  reg [15:0] hostCfg_q;
  reg [15:0] periphCfg_q;
  reg [7:0] cmd_q;
  reg [15:0] dataOut_q;
  reg dataOe_q;
  reg hostPop_q;
  reg periphPop_q;
  reg mergedOwner_q;
  reg grantPrev_q;
  wire bufReady;
  wire bufFull;
  wire rdFall;
  wire wrRise;
  wire hostGrantAct;
  wire periphGrantAct;
  wire merge;
  wire dmaActive;
  wire dmaPart;
  wire hostReqLevel;
  wire periphReqLevel;
  wire pioSel;
  wire pushValid;
  reg [15:0] pioRdData;

  // Two flip-flops on every asynchronous pin before any logic looks at it.
  always @(posedge clk) begin
    if (!nrst) begin
      csSync_q <= 2'h3;
      rdSync_q <= 2'h3;
      wrSync_q <= 2'h3;
      cmdSync_q <= 2'h0;
      grantHostSync_q <= 2'h3;
      grantPeriphSync_q <= 2'h3;
      dataSyncA_q <= 16'h0000;
      dataSyncB_q <= 16'h0000;
    end else begin
      csSync_q <= {csSync_q[0], csN};
      rdSync_q <= {rdSync_q[0], rdN};
      wrSync_q <= {wrSync_q[0], wrN};
      cmdSync_q <= {cmdSync_q[0], cmdPhase};
      grantHostSync_q <= {grantHostSync_q[0], dmaGrantHost};
      grantPeriphSync_q <= {grantPeriphSync_q[0], dmaGrantPeriph};
      dataSyncA_q <= dataIn;
      dataSyncB_q <= dataSyncA_q;
    end
  end

  // Previous values; write data and select are taken from the cycle before the write edge.
  always @(posedge clk) begin
    if (!nrst) begin
      rdPrev_q <= 1'b1;
      wrPrev_q <= 1'b1;
      csPrev_q <= 1'b1;
      cmdPrev_q <= 1'b0;
      dataPrev_q <= 16'h0000;
    end else begin
      rdPrev_q <= rdSync_q[1];
      wrPrev_q <= wrSync_q[1];
      csPrev_q <= csSync_q[1];
      cmdPrev_q <= cmdSync_q[1];
      dataPrev_q <= dataSyncB_q;
    end
  end

  // ==========================================================
  // Strobe edges and grant decode.
  assign rdFall = rdPrev_q & ~rdSync_q[1];
  assign wrRise = ~wrPrev_q & wrSync_q[1];
  assign merge = hostCfg_q[`HBDH_BIT_MERGE];
  assign hostGrantAct = grantHostSync_q[1] ~^ hostCfg_q[`HBDH_BIT_GRANT_POL]; // RULE8
  assign periphGrantAct = grantPeriphSync_q[1] ~^ periphCfg_q[`HBDH_BIT_GRANT_POL]; // RULE9
  // In merged mode the second grant pin is not looked at.
  assign dmaActive = hostGrantAct | (~merge & periphGrantAct); // RULE7
  assign dmaPart = merge ? mergedOwner_q : ~hostGrantAct;
  // Register access only when chip select was low and no grant is active.
  assign pioSel = ~csPrev_q & ~dmaActive; // RULE2

  // Merged channel owner is chosen when the grant goes active; the host part wins a tie.
  always @(posedge clk) begin
    if (!nrst) begin
      grantPrev_q <= 1'b0;
      mergedOwner_q <= 1'b0;
    end else begin
      grantPrev_q <= hostGrantAct;
      if (hostGrantAct && !grantPrev_q) begin
        mergedOwner_q <= ~hostPartNeed & periphPartNeed; // RULE7
      end
    end
  end

  // ==========================================================
  // Requests: withdrawn only once the write buffer is full, so an in-flight word finds no room and is refused.
  assign hostReqLevel = merge ? ((hostPartNeed | periphPartNeed) & bufReady) : (hostPartNeed & bufReady);
  assign periphReqLevel = ~merge & periphPartNeed & bufReady;
  assign dmaRequestHost = ~(hostReqLevel ^ hostCfg_q[`HBDH_BIT_REQ_POL]); // RULE5
  assign dmaRequestPeriph = ~(periphReqLevel ^ periphCfg_q[`HBDH_BIT_REQ_POL]); // RULE6

  // ==========================================================
  // Register read mux; unmapped commands read as zero.
  always @* begin
    case (cmd_q)
      `HBDH_CMD_HOST_CFG_RD: pioRdData = hostCfg_q;
      `HBDH_CMD_PERIPH_CFG_RD: pioRdData = periphCfg_q;
      `HBDH_CMD_STATUS_RD: pioRdData = {12'h000, mergedOwner_q, dmaActive, bufFull, dmaWrValid};
      default: pioRdData = 16'h0000;
    endcase
  end

  // Command and configuration writes on the rising edge of the write strobe.
  always @(posedge clk) begin
    if (!nrst) begin
      cmd_q <= `HBDH_CMD_RST;
      hostCfg_q <= `HBDH_HOST_CFG_RST;
      periphCfg_q <= `HBDH_PERIPH_CFG_RST;
    end else if (wrRise && pioSel) begin
      if (cmdPrev_q) begin
        cmd_q <= dataPrev_q[7:0];
      end else if (cmd_q == `HBDH_CMD_HOST_CFG_WR) begin
        hostCfg_q <= dataPrev_q; // RULE4
      end else if (cmd_q == `HBDH_CMD_PERIPH_CFG_WR) begin
        periphCfg_q <= dataPrev_q; // RULE4
      end
    end
  end

  // ==========================================================
  // Read path: the bus is driven from the read strobe's start until its release.
  always @(posedge clk) begin
    if (!nrst) begin
      dataOut_q <= 16'h0000;
      dataOe_q <= 1'b0;
      hostPop_q <= 1'b0;
      periphPop_q <= 1'b0;
    end else begin
      hostPop_q <= 1'b0;
      periphPop_q <= 1'b0;
      if (rdSync_q[1]) begin
        dataOe_q <= 1'b0; // RULE1
      end else if (rdFall && dmaActive) begin
        dataOe_q <= 1'b1;
        dataOut_q <= dmaPart ? periphPartRdData : hostPartRdData; // RULE10
        hostPop_q <= ~dmaPart;
        periphPop_q <= dmaPart;
      end else if (rdFall && !csSync_q[1]) begin
        dataOe_q <= 1'b1; // RULE3
        dataOut_q <= pioRdData;
      end
    end
  end

  assign dataOut = dataOut_q;
  assign dataOe = dataOe_q;
  assign hostPartRdPop = hostPop_q;
  assign periphPartRdPop = periphPop_q;

  // ==========================================================
  // Write path under a grant; the buffer absorbs a stall of the receiving part.
  assign pushValid = wrRise & dmaActive; // RULE10

  hbdh_buffer #(
    .WIDTH(`HBDH_BUF_W)
  ) u_buf (
    .clk(clk),
    .nrst(nrst),
    .inValid(pushValid),
    .inReady(bufReady),
    .inData({dmaPart, dataPrev_q}),
    .outValid(dmaWrValid),
    .outReady(dmaWrReady),
    .outData(dmaWrData),
    .full(bufFull)
  );

endmodule

// file: test/hbdh_checker.sv
// Purpose: Port-level checks of the host bus and DMA handshake block.
// Assumes: One clock domain; nrst synchronous, active low.
// Notes: Polarity-dependent pins are judged by the bench, not here.
// ==========
// Checker module.
module hbdh_checker (
  // Clock and reset.
  input wire clk,
  input wire nrst,
  // Bus side.
  input wire rdN,
  input wire [15:0] dataOut,
  input wire dataOe,
  // Part and buffer side.
  input wire hostPartRdPop,
  input wire periphPartRdPop,
  input wire dmaWrValid,
  input wire dmaWrReady,
  input wire [16:0] dmaWrData
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // The strobe crosses two flops, so the drive may only start after two low samples.
  wire anyPop = hostPartRdPop || periphPartRdPop;
  a_oe_rise_read: assert property ($rose(dataOe) |-> !$past(rdN, 1) && !$past(rdN, 2))
    else $error("bus driven without a read strobe");
  a_oe_release: assert property (rdN [*6] |-> !dataOe)
    else $error("bus still driven after the read ended");
  a_out_stands: assert property (dataOe && $past(dataOe) |-> $stable(dataOut))
    else $error("read data moved while driven");
  a_pop_with_oe: assert property (anyPop |-> $rose(dataOe))
    else $error("word popped outside a read start");
  a_pop_pulse: assert property (anyPop |=> !anyPop)
    else $error("pop longer than one cycle");
  a_pops_excl: assert property (!(hostPartRdPop && periphPartRdPop))
    else $error("both parts popped at once");
  a_buf_holds: assert property (dmaWrValid && !dmaWrReady |=> dmaWrValid && $stable(dmaWrData))
    else $error("stalled word changed or vanished");
  a_wrv_fall: assert property ($fell(dmaWrValid) |-> $past(dmaWrReady))
    else $error("word left without being taken");
  cover property ($rose(dataOe));
  cover property (periphPartRdPop);
  cover property (dmaWrValid && !dmaWrReady);
endmodule

bind hbdh_top hbdh_checker i_chk (.clk(clk), .nrst(nrst), .rdN(rdN), .dataOut(dataOut), .dataOe(dataOe),
  .hostPartRdPop(hostPartRdPop), .periphPartRdPop(periphPartRdPop), .dmaWrValid(dmaWrValid),
  .dmaWrReady(dmaWrReady), .dmaWrData(dmaWrData));

// file: test/hbdh_dma_model.sv
// Purpose: Behavioural DMA controller channel facing one request pin.
// Assumes: Polarities are told by the bench as it programs the block.
// Notes: Grant is held until en drops, so a full buffer cannot end a burst early.
// ==========
// Channel model.
module hbdh_dma_model (
  // Clock and reset.
  input wire clk,
  input wire nrst,
  // Control from the bench.
  input wire en,
  input wire reqPol,
  input wire grantPol,
  input wire [1:0] lat,
  // Pins.
  input wire req,
  output wire grant
);
  timeunit 1ns;
  timeprecision 1ns;
  logic on_q;
  logic [1:0] cnt_q;
  wire reqAct = (req == reqPol);
  // Grant after lat extra cycles of active request, so slow answers are exercised.
  always @(posedge clk) begin
    if (!nrst || !en) begin
      on_q <= 1'b0;
      cnt_q <= 2'h0;
    end else if (!on_q && reqAct) begin
      cnt_q <= cnt_q + 2'h1;
      on_q <= (cnt_q == lat);
    end
  end
  assign grant = on_q ? grantPol : ~grantPol;
endmodule

// file: test/tb.sv
// Purpose: Self-checking bench of the host bus and DMA handshake block.
// Assumes: Inputs change at the rising edge; outputs are read at the falling edge.
// Notes: Released bus lines toggle every cycle so stale data never passes.
// ==========
// Bench top.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, nrst = 0, csN = 1, rdN = 1, wrN = 1, cmdPhase = 0, drv = 0;
  logic [15:0] wdat = 0, idleV = 0, hData = 0, pData = 0, v, hv, pv;
  logic hNeed = 0, pNeed = 0, wrRdy = 0, hEn = 0, pEn = 0, hRp = 0, hGp = 0, pRp = 0, pGp = 0, oe;
  logic [15:0] wq [3];
  wire [15:0] dataOut, bus;
  wire dataOe, rqH, rqP, gH, gP, popH, popP, wrV;
  wire [16:0] wrD;
  int error_cnt = 0, n_compared = 0, cycles = 0, pops = 0;
  // The wire level follows whoever enables it; nobody means a changing pattern.
  assign bus = dataOe ? dataOut : (drv ? wdat : idleV);
  initial forever #50 clk = ~clk;
  always @(posedge clk) begin
    idleV <= ~idleV;
    cycles <= cycles + 1;
    pops <= pops + (popP ? 1 : 0);
    if (cycles == 8000) begin
      error_cnt++;
      results();
    end
  end
  hbdh_top i_dut (.clk(clk), .nrst(nrst), .csN(csN), .rdN(rdN), .wrN(wrN), .cmdPhase(cmdPhase),
    .dataIn(bus), .dataOut(dataOut), .dataOe(dataOe), .dmaRequestHost(rqH), .dmaRequestPeriph(rqP),
    .dmaGrantHost(gH), .dmaGrantPeriph(gP), .hostPartNeed(hNeed), .hostPartRdData(hData),
    .hostPartRdPop(popH), .periphPartNeed(pNeed), .periphPartRdData(pData), .periphPartRdPop(popP),
    .dmaWrValid(wrV), .dmaWrReady(wrRdy), .dmaWrData(wrD));
  hbdh_dma_model i_mh (.clk(clk), .nrst(nrst), .en(hEn), .reqPol(hRp), .grantPol(hGp), .lat(2'h0),
    .req(rqH), .grant(gH));
  hbdh_dma_model i_mp (.clk(clk), .nrst(nrst), .en(pEn), .reqPol(pRp), .grantPol(pGp), .lat(2'h3),
    .req(rqP), .grant(gP));
  function logic lvl(input logic act, input logic pol);
    return act ? pol : ~pol;
  endfunction
  task results();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input string nm, input logic [16:0] e, input logic [16:0] s);
    n_compared++;
    if (s !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
      error_cnt++;
    end
  endtask
  // Data is held four edges past the strobe rise, covering the two-flop capture.
  task pw(input logic c, input logic [15:0] d, input logic cs);
    cmdPhase <= c; wdat <= d; csN <= cs; wrN <= 1'b0; drv <= 1'b1;
    repeat (4) @(posedge clk);
    wrN <= 1'b1;
    repeat (4) @(posedge clk);
    drv <= 1'b0; csN <= 1'b1;
    @(posedge clk);
  endtask
  task pr(input logic cs, output logic [15:0] d, output logic e);
    csN <= cs; rdN <= 1'b0;
    repeat (5) @(posedge clk);
    @(negedge clk);
    d = dataOut; e = dataOe;
    @(posedge clk);
    rdN <= 1'b1;
    repeat (5) @(posedge clk);
    csN <= 1'b1;
    @(posedge clk);
  endtask
  task regw(input logic [7:0] c, input logic [15:0] d);
    pw(1'b1, {8'h00, c}, 1'b0);
    pw(1'b0, d, 1'b0);
  endtask
  task regr(input logic [7:0] c, output logic [15:0] d);
    pw(1'b1, {8'h00, c}, 1'b0);
    pr(1'b0, d, oe);
  endtask
  // ==========
  // Main sequence.
  initial begin
    v = 16'($urandom(32'ha9c2980d));
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    regr(8'h20, v); chk("host_cfg_rst", 16'h0000, v);
    regr(8'hbb, v); chk("periph_cfg_rst", 16'h0000, v);
    // Low three bits stay clear so grants cannot turn active by accident.
    for (int i = 0; i < 3; i++) begin
      hv = 16'($urandom) & 16'hfff8; pv = 16'($urandom) & 16'hfff8;
      regw(8'ha0, hv); regw(8'hba, pv);
      regr(8'h20, v); chk("host_cfg", hv, v);
      regr(8'hbb, v); chk("periph_cfg", pv, v);
    end
    regr(8'h55, v); chk("unmapped", 16'h0000, v);
    pw(1'b1, 16'h00a0, 1'b1); pw(1'b0, 16'h1238, 1'b1);
    regr(8'h20, v); chk("cs_high_wr", hv, v);
    pr(1'b1, v, oe); chk("cs_high_rd", 1'b0, oe);
    chk("bus_idle", 1'b0, dataOe);
    $display("register test done");
    for (int k = 0; k < 16; k++) begin
      regw(8'ha0, {13'h0, k[3], 1'b0, k[2]}); regw(8'hba, {15'h0, k[2]});
      hNeed <= k[1]; pNeed <= k[0];
      @(negedge clk);
      chk("req_host", lvl(k[1] | (k[3] & k[0]), k[2]), rqH);
      chk("req_periph", lvl(k[0] & !k[3], k[2]), rqP);
      @(posedge clk);
    end
    hNeed <= 1'b0; pNeed <= 1'b0;
    $display("request test done");
    // Peripheral config goes first: the idle host grant pin reads active once host polarity turns high.
    regw(8'hba, 16'h0000); regw(8'ha0, 16'h0003);
    hRp <= 1'b1; hGp <= 1'b1; pRp <= 1'b0; pGp <= 1'b0; hNeed <= 1'b1; hEn <= 1'b1;
    repeat (6) @(posedge clk);
    for (int j = 0; j < 3; j++) begin
      wq[j] = 16'($urandom);
      pw(1'b0, wq[j], 1'b0);
    end
    chk("req_full", 1'b0, rqH);
    // With the grant withdrawn the status word must show a full buffer holding valid words.
    hEn <= 1'b0;
    repeat (4) @(posedge clk);
    regr(8'h24, v); chk("status_full", 16'h0003, v);
    for (int j = 0; j < 2; j++) begin
      @(negedge clk); chk("dma_wr", {1'b0, wq[j]}, wrD);
      @(posedge clk) wrRdy <= 1'b1;
      @(posedge clk) wrRdy <= 1'b0;
    end
    @(negedge clk); chk("buf_empty", 1'b0, wrV);
    @(posedge clk) hEn <= 1'b0;
    hNeed <= 1'b0;
    repeat (6) @(posedge clk);
    $display("dma write test done");
    pData <= 16'($urandom); pNeed <= 1'b1; pEn <= 1'b1;
    repeat (10) @(posedge clk);
    pr(1'b0, v, oe); chk("dma_rd", pData, v);
    chk("dma_rd_oe", 1'b1, oe); chk("dma_pops", 1, pops);
    $display("dma read test done");
    // Merged channel: the first grant serves the peripheral part when only that part needs data.
    pEn <= 1'b0;
    repeat (6) @(posedge clk);
    regw(8'ha0, 16'h0007); hEn <= 1'b1;
    repeat (8) @(posedge clk);
    pr(1'b0, v, oe); chk("merged_rd", pData, v); chk("merged_pops", 2, pops);
    chk("merged_req_periph", 1'b1, rqP);
    $display("merged dma test done");
    results();
  end
endmodule
